// ==== tdc_regs_params.svh ====
// Register offsets, field positions, reset values and sizes of the bank.
`ifndef TDC_REGS_PARAMS_SVH
`define TDC_REGS_PARAMS_SVH
`define ADDR_START_GATING   4'h5
`define ADDR_FIFO_THRESHOLD 4'h6
`define ADDR_PLL_TIMER      4'h7
`define ADDR_RESULT_ONE     4'h8
`define ADDR_RESULT_TWO     4'h9
`define ADDR_FIRST_GAP      4'ha
`define ADDR_BUS_WIDTH      4'he
`define BIT_HALF_WIDTH_MODE 4
`define HALF_WORD_BITS      16
`define UPPER_WORD_BITS     12
`define CONFIG_RESET        108'h0
`define RESULT_FIFO_DEPTH   32
`define BUS_DATA_BITS       28
`endif

// ==== tdc_regs_pkg.sv ====
// Types shared by the register bank, its checker, host model and bench.
package tdc_regs_pkg;
	typedef enum logic [1:0] {
		MODE_EIGHT_CHANNEL,
		MODE_TWO_CHANNEL_FINE,
		MODE_TWO_CHANNEL,
		MODE_SINGLE_SHOT
	} meas_mode_t;

	typedef struct packed {
		logic [22:0] interval;
		logic        edge_direction;
		logic [7:0]  start_number;
		logic [1:0]  channel_index;
	} hit_t;

	typedef struct packed {
		logic        chip_select_n;
		logic        read_n;
		logic        write_n;
		logic [3:0]  address;
		logic [27:0] data;
	} bus_pins_t;

	typedef struct packed {
		logic [17:0] start_offset_primary;
		logic [2:0]  service_adjust_bits;
		logic        stop_gate_until_start;
		logic        start_gate_after_start;
		logic        full_reset_on_trigger_pin;
		logic        part_reset_on_trigger_pin;
		logic        full_reset_on_output_enable_pin;
		logic        part_reset_on_output_enable_pin;
		logic        external_start_repeat;
		logic [7:0]  fifo_fill_threshold;
		logic [17:0] start_offset_secondary;
		logic        differential_input_routing;
		logic        differential_receiver_power;
		logic [7:0]  pll_fast_divider;
		logic [2:0]  pll_reference_divider;
		logic        resolution_regulation_on;
		logic        pll_phase_invert;
		logic        pll_loop_open;
		logic        pll_service_bit;
		logic [12:0] measurement_timer;
		logic        half_width_bus_mode;
		logic [22:0] spare;
	} config_t;
endpackage

// ==== tdc_config_readout_registers.sv ====
// Register bank with result queues of the time-to-digital converter.
//
// How it works
// - two 18-bit start offsets in words five, six
// - stop inputs gated until a start arrives
// - start gated after first start, not eight-channel
// - trigger pin high gives full reset, unless quiet
// - trigger pin high gives partial reset, unless quiet
// - output enable low gives full reset, pin spare
// - output enable low gives partial reset, pin spare
// - word six low byte sets level flag threshold
// - threshold reads back inverted, other bits unchanged
// - eight-channel stop routing select bit stored, driven
// - differential receiver power bit stored, driven
// - PLL fast divider in word seven bits 0-7
// - PLL reference divider in bits 8-10
// - resolution regulation enable in bit 11
// - phase invert, loop open, service bit zero
// - measurement timer in bits 15-27
// - word fourteen bit four selects half-width bus
// - eight-channel result word field layout
// - first start gap returned in word ten, eight-channel only
// - two-channel result layouts with or without slope
`timescale 1ns/1ns
`include "tdc_regs_params.svh"

module result_queue #(
	parameter int WIDTH = `BUS_DATA_BITS,
	parameter int DEPTH = `RESULT_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   flush,
	// Filling side.
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [WIDTH-1:0]       in_data,
	// Draining side.
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [WIDTH-1:0]            out_data,
	output logic [$clog2(DEPTH):0]      fill
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [PW:0]                 count;
		logic                        full;
	} queue_state_t;

	queue_state_t state;
	queue_state_t next_state;
	logic         push;
	logic         pop;

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH)
			$error("result_queue depth must be a power of two");
	end

	assign in_ready  = !state.full;
	assign out_valid = state.count != '0;
	assign out_data  = state.mem[state.rd_ptr];
	assign fill      = state.count;

	always_comb begin
		next_state = state;
		push = in_valid && !state.full;
		pop  = out_ready && out_valid;
		if (push) begin
			next_state.mem[state.wr_ptr] = in_data;
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (pop)
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		if (push && !pop)
			next_state.count = state.count + 1'b1;
		else if (pop && !push)
			next_state.count = state.count - 1'b1;
		next_state.full = next_state.count == (PW+1)'(DEPTH);
		if (flush) begin
			next_state.wr_ptr = '0;
			next_state.rd_ptr = '0;
			next_state.count  = '0;
			next_state.full   = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

module tdc_config_readout_registers #(
	parameter int FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                   clock,
	input  wire logic                   resetn,
	// Asynchronous parallel bus pins.
	input  wire tdc_regs_pkg::bus_pins_t bus_pins,
	output logic [27:0]                 data_out,
	output logic                        data_oe,
	// Reset request pins.
	input  wire logic                   alu_trigger_pin,
	input  wire logic                   output_enable_pin,
	// Measurement core status.
	input  wire tdc_regs_pkg::meas_mode_t meas_mode,
	input  wire logic                   quiet_mode,
	input  wire logic                   output_enable_pin_spare,
	input  wire logic                   start_pulse,
	input  wire logic [16:0]            first_start_gap,
	// Result streams from the measurement core.
	input  wire tdc_regs_pkg::hit_t     hit_one,
	input  wire logic                   hit_one_valid,
	output logic                        hit_one_ready,
	input  wire tdc_regs_pkg::hit_t     hit_two,
	input  wire logic                   hit_two_valid,
	output logic                        hit_two_ready,
	// Configuration and control towards the core.
	output tdc_regs_pkg::config_t       config_out,
	output logic                        stop_inputs_enabled,
	output logic                        start_input_enabled,
	output logic                        full_reset,
	output logic                        part_reset,
	output logic [1:0]                  fifo_level_flag,
	output logic [1:0]                  fifo_empty
);
	import tdc_regs_pkg::*;

	localparam int FW = $clog2(FIFO_DEPTH);

	typedef struct packed {
		bus_pins_t   bus_a;
		bus_pins_t   bus_b;
		logic [1:0]  trig_a;
		logic [1:0]  trig_b;
		logic        prev_read_n;
		logic        prev_write_n;
		config_t     cfg;
		logic [27:0] read_word;
		logic [3:0]  read_addr;
		logic        read_half;
		logic [15:0] write_low;
		logic        write_half;
		logic [27:0] data_out;
		logic        data_oe;
		logic [1:0]  pop;
		logic        start_seen;
		logic        stop_enable;
		logic        start_enable;
		logic        full_reset;
		logic        part_reset;
		logic [1:0]  level_flag;
		logic [1:0]  empty;
	} bank_state_t;

	bank_state_t        state;
	bank_state_t        next_state;
	logic [27:0]        queue_in [2];
	logic [27:0]        queue_out [2];
	logic [1:0]         queue_valid;
	logic [FW:0]        queue_fill [2];

	initial begin
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255)
			$error("FIFO_DEPTH must lie between 2 and 255");
	end

	function automatic logic [27:0] format_hit(meas_mode_t m, hit_t h);
		unique case (m)
			MODE_EIGHT_CHANNEL:
				format_hit = {h.channel_index, h.start_number,
					h.edge_direction, h.interval[16:0]};
			MODE_TWO_CHANNEL_FINE:
				format_hit = {5'h0, h.edge_direction, h.interval[21:0]};
			default:
				format_hit = {5'h0, h.interval};
		endcase
	endfunction

	function automatic logic [27:0] read_mux(bank_state_t s,
		logic [3:0] a, logic [1:0] v, logic [27:0] q0, logic [27:0] q1,
		meas_mode_t m, logic [16:0] gap);
		read_mux = 28'h0;
		unique case (a)
			`ADDR_START_GATING:
				read_mux = {s.cfg.external_start_repeat,
					s.cfg.part_reset_on_output_enable_pin,
					s.cfg.full_reset_on_output_enable_pin,
					s.cfg.part_reset_on_trigger_pin,
					s.cfg.full_reset_on_trigger_pin,
					s.cfg.start_gate_after_start,
					s.cfg.stop_gate_until_start,
					s.cfg.service_adjust_bits,
					s.cfg.start_offset_primary};
			`ADDR_FIFO_THRESHOLD:
				read_mux = {s.cfg.differential_receiver_power,
					s.cfg.differential_input_routing,
					s.cfg.start_offset_secondary,
					~s.cfg.fifo_fill_threshold};
			`ADDR_PLL_TIMER:
				read_mux = {s.cfg.measurement_timer,
					s.cfg.pll_service_bit, s.cfg.pll_loop_open,
					s.cfg.pll_phase_invert,
					s.cfg.resolution_regulation_on,
					s.cfg.pll_reference_divider,
					s.cfg.pll_fast_divider};
			`ADDR_RESULT_ONE:
				read_mux = v[0] ? q0 : 28'h0;
			`ADDR_RESULT_TWO:
				read_mux = v[1] ? q1 : 28'h0;
			`ADDR_FIRST_GAP:
				read_mux = (m == MODE_EIGHT_CHANNEL) ? {11'h0, gap} : 28'h0;
			`ADDR_BUS_WIDTH:
				read_mux = {23'h0, s.cfg.half_width_bus_mode, 4'h0};
			default:
				read_mux = 28'h0;
		endcase
	endfunction

	// Field writes of one committed word; service bits are kept as written.
	function automatic config_t write_word(config_t c, logic [3:0] a,
		logic [27:0] d);
		write_word = c;
		unique case (a)
			`ADDR_START_GATING: begin
				write_word.start_offset_primary            = d[17:0];
				write_word.service_adjust_bits             = d[20:18];
				write_word.stop_gate_until_start           = d[21];
				write_word.start_gate_after_start          = d[22];
				write_word.full_reset_on_trigger_pin       = d[23];
				write_word.part_reset_on_trigger_pin       = d[24];
				write_word.full_reset_on_output_enable_pin = d[25];
				write_word.part_reset_on_output_enable_pin = d[26];
				write_word.external_start_repeat           = d[27];
			end
			`ADDR_FIFO_THRESHOLD: begin
				write_word.fifo_fill_threshold         = d[7:0];
				write_word.start_offset_secondary      = d[25:8];
				write_word.differential_input_routing  = d[26];
				write_word.differential_receiver_power = d[27];
			end
			`ADDR_PLL_TIMER: begin
				write_word.pll_fast_divider         = d[7:0];
				write_word.pll_reference_divider    = d[10:8];
				write_word.resolution_regulation_on = d[11];
				write_word.pll_phase_invert         = d[12];
				write_word.pll_loop_open            = d[13];
				write_word.pll_service_bit          = d[14];
				write_word.measurement_timer        = d[27:15];
			end
			`ADDR_BUS_WIDTH:
				write_word.half_width_bus_mode = d[`BIT_HALF_WIDTH_MODE];
			default:
				write_word = c;
		endcase
	endfunction

	assign queue_in[0] = format_hit(meas_mode, hit_one);
	assign queue_in[1] = format_hit(meas_mode, hit_two);

	result_queue #(
		.WIDTH (`BUS_DATA_BITS),
		.DEPTH (FIFO_DEPTH)
	) queue_one (
		.clock     (clock),
		.resetn    (resetn),
		.flush     (state.full_reset),
		.in_valid  (hit_one_valid),
		.in_ready  (hit_one_ready),
		.in_data   (queue_in[0]),
		.out_valid (queue_valid[0]),
		.out_ready (state.pop[0]),
		.out_data  (queue_out[0]),
		.fill      (queue_fill[0])
	);

	result_queue #(
		.WIDTH (`BUS_DATA_BITS),
		.DEPTH (FIFO_DEPTH)
	) queue_two (
		.clock     (clock),
		.resetn    (resetn),
		.flush     (state.full_reset),
		.in_valid  (hit_two_valid),
		.in_ready  (hit_two_ready),
		.in_data   (queue_in[1]),
		.out_valid (queue_valid[1]),
		.out_ready (state.pop[1]),
		.out_data  (queue_out[1]),
		.fill      (queue_fill[1])
	);

	always_comb begin
		logic        rd_fall;
		logic        wr_rise;
		logic [27:0] word;
		logic        is_result;
		next_state = state;
		rd_fall = 1'b0;
		wr_rise = 1'b0;
		word = 28'h0;
		is_result = 1'b0;
		// Pins pass two flops; only the second stage is looked at.
		next_state.bus_a  = bus_pins;
		next_state.bus_b  = state.bus_a;
		next_state.trig_a = {alu_trigger_pin, output_enable_pin};
		next_state.trig_b = state.trig_a;
		next_state.prev_read_n  = state.bus_b.read_n;
		next_state.prev_write_n = state.bus_b.write_n;
		next_state.pop = 2'b00;
		rd_fall = state.prev_read_n && !state.bus_b.read_n &&
			!state.bus_b.chip_select_n;
		wr_rise = !state.prev_write_n && state.bus_b.write_n &&
			!state.bus_b.chip_select_n;
		next_state.data_oe = !state.bus_b.chip_select_n &&
			!state.bus_b.read_n;

		// halves pair low first, then high.
		if (rd_fall) begin
			if (state.cfg.half_width_bus_mode && state.read_half) begin
				next_state.data_out  = {16'h0, state.read_word[27:16]};
				next_state.read_half = 1'b0;
				is_result = state.read_addr == `ADDR_RESULT_ONE ||
					state.read_addr == `ADDR_RESULT_TWO;
			end else begin
				word = read_mux(state, state.bus_b.address, queue_valid,
					queue_out[0], queue_out[1], meas_mode, first_start_gap);
				next_state.read_word = word;
				next_state.read_addr = state.bus_b.address;
				if (state.cfg.half_width_bus_mode) begin
					next_state.data_out  = {12'h0, word[15:0]};
					next_state.read_half = 1'b1;
				end else begin
					next_state.data_out = word;
					is_result = state.bus_b.address == `ADDR_RESULT_ONE ||
						state.bus_b.address == `ADDR_RESULT_TWO;
				end
			end
			if (is_result)
				next_state.pop = {next_state.read_addr[0],
					!next_state.read_addr[0]};
		end

		if (wr_rise) begin
			if (state.cfg.half_width_bus_mode && !state.write_half) begin
				next_state.write_low  = state.bus_b.data[15:0];
				next_state.write_half = 1'b1;
			end else if (state.cfg.half_width_bus_mode) begin
				next_state.write_half = 1'b0;
				next_state.cfg = write_word(state.cfg, state.bus_b.address,
					{state.bus_b.data[11:0], state.write_low});
			end else begin
				next_state.cfg = write_word(state.cfg, state.bus_b.address,
					state.bus_b.data);
			end
		end

		// full reset from trigger pin or output enable pin.
		next_state.full_reset =
			(state.trig_b[1] && state.cfg.full_reset_on_trigger_pin &&
			 !quiet_mode) ||
			(!state.trig_b[0] && output_enable_pin_spare &&
			 state.cfg.full_reset_on_output_enable_pin);
		// partial reset from trigger pin or output enable pin.
		next_state.part_reset =
			(state.trig_b[1] && state.cfg.part_reset_on_trigger_pin &&
			 !quiet_mode) ||
			(!state.trig_b[0] && output_enable_pin_spare &&
			 state.cfg.part_reset_on_output_enable_pin);

		// A start in the same cycle as a reset still counts.
		if (state.full_reset || state.part_reset)
			next_state.start_seen = 1'b0;
		if (start_pulse)
			next_state.start_seen = 1'b1;
		next_state.stop_enable = !(state.cfg.stop_gate_until_start &&
			!next_state.start_seen);
		next_state.start_enable = !(state.cfg.start_gate_after_start &&
			next_state.start_seen && meas_mode != MODE_EIGHT_CHANNEL);

		for (int i = 0; i < 2; i++) begin
			next_state.level_flag[i] = 8'(queue_fill[i]) >=
				state.cfg.fifo_fill_threshold;
			next_state.empty[i] = !queue_valid[i];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= '0;
			state.prev_read_n  <= 1'b1;
			state.prev_write_n <= 1'b1;
			state.bus_a <= {3'b111, 32'h0};
			state.bus_b <= {3'b111, 32'h0};
			state.trig_a <= 2'b01;
			state.trig_b <= 2'b01;
			state.cfg <= `CONFIG_RESET;
			state.stop_enable  <= 1'b1;
			state.start_enable <= 1'b1;
			state.empty <= 2'b11;
		end else begin
			state <= next_state;
		end
	end

	assign data_out            = state.data_out;
	assign data_oe             = state.data_oe;
	assign config_out          = state.cfg;
	assign stop_inputs_enabled = state.stop_enable;
	assign start_input_enabled = state.start_enable;
	assign full_reset          = state.full_reset;
	assign part_reset          = state.part_reset;
	assign fifo_level_flag     = state.level_flag;
	assign fifo_empty          = state.empty;
endmodule

// ==== placeholder_unused.sv ====
`timescale 1ns/1ns

// ==== tdc_config_readout_registers_assertions.sv ====
// Concurrent checks on the reset pins and input gating of the register bank.
`timescale 1ns/1ns
module tdc_regs_checker (
	// Clock and reset.
	input wire logic                     clock,
	input wire logic                     resetn,
	// Reset request pins and their qualifiers.
	input wire logic                     alu_trigger_pin,
	input wire logic                     output_enable_pin,
	input wire logic                     quiet_mode,
	input wire logic                     output_enable_pin_spare,
	// Core side.
	input wire tdc_regs_pkg::meas_mode_t meas_mode,
	input wire logic                     start_pulse,
	input wire tdc_regs_pkg::config_t    config_out,
	input wire logic                     stop_inputs_enabled,
	input wire logic                     start_input_enabled,
	input wire logic                     full_reset,
	input wire logic                     part_reset
);
	import tdc_regs_pkg::*;
	logic trig_on;
	logic oen_on;
	assign trig_on = alu_trigger_pin && !quiet_mode;
	assign oen_on = !output_enable_pin && output_enable_pin_spare;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Four stable samples cover the two synchroniser stages and the register.
	a_trig_full_reset: assert property (
		(trig_on && config_out.full_reset_on_trigger_pin)[*4] |-> full_reset)
		else $error("trigger pin gave no full reset");
	a_trig_part_reset: assert property (
		(trig_on && config_out.part_reset_on_trigger_pin)[*4] |-> part_reset)
		else $error("trigger pin gave no partial reset");
	a_oen_full_reset: assert property (
		(oen_on && config_out.full_reset_on_output_enable_pin)[*4]
		|-> full_reset) else $error("enable pin gave no full reset");
	a_oen_part_reset: assert property (
		(oen_on && config_out.part_reset_on_output_enable_pin)[*4]
		|-> part_reset) else $error("enable pin gave no partial reset");
	a_full_reset_idle: assert property (
		(!(trig_on && config_out.full_reset_on_trigger_pin) &&
		!(oen_on && config_out.full_reset_on_output_enable_pin))[*4]
		|-> !full_reset) else $error("full reset without a cause");
	a_part_reset_idle: assert property (
		(!(trig_on && config_out.part_reset_on_trigger_pin) &&
		!(oen_on && config_out.part_reset_on_output_enable_pin))[*4]
		|-> !part_reset) else $error("partial reset without a cause");
	a_stop_gate_hold: assert property (
		!stop_inputs_enabled && !start_pulse && !$past(start_pulse) &&
		config_out.stop_gate_until_start |=> !stop_inputs_enabled ||
		!config_out.stop_gate_until_start)
		else $error("stop inputs opened before a start");
	a_stop_gate_open: assert property (
		start_pulse ##1 (!full_reset && !part_reset)[*3]
		|-> stop_inputs_enabled) else $error("stop inputs stayed closed");
	a_start_gate_shut: assert property (
		start_pulse ##1 (meas_mode != MODE_EIGHT_CHANNEL && !full_reset &&
		!part_reset && config_out.start_gate_after_start)[*3]
		|-> !start_input_enabled) else $error("start input stayed open");
	a_start_eight_open: assert property (
		(meas_mode == MODE_EIGHT_CHANNEL)[*2] |-> start_input_enabled)
		else $error("start input closed in eight-channel mode");
endmodule

bind tdc_config_readout_registers tdc_regs_checker i_checker (
	.clock(clock), .resetn(resetn), .alu_trigger_pin(alu_trigger_pin),
	.output_enable_pin(output_enable_pin), .quiet_mode(quiet_mode),
	.output_enable_pin_spare(output_enable_pin_spare),
	.meas_mode(meas_mode), .start_pulse(start_pulse),
	.config_out(config_out), .stop_inputs_enabled(stop_inputs_enabled),
	.start_input_enabled(start_input_enabled), .full_reset(full_reset),
	.part_reset(part_reset));

// ==== tdc_host_model.sv ====
// Host model that moves words over the asynchronous parallel bus.
`timescale 1ns/1ns
module tdc_host_model (
	// Clock.
	input  wire logic                 clock,
	// Bus towards the register bank.
	output tdc_regs_pkg::bus_pins_t   bus_pins,
	input  wire logic [27:0]          data_out,
	input  wire logic                 data_oe
);
	import tdc_regs_pkg::*;
	bit half;
	initial begin
		half = 1'b0;
		bus_pins = {3'b111, 4'h0, 28'h0};
	end

	// The bus has no ready, so every phase is held well past the sampler.
	task automatic strobe(input logic [3:0] a, input logic [27:0] d,
			input bit wr, output logic [27:0] q);
		@(negedge clock);
		bus_pins.chip_select_n = 1'b0;
		bus_pins.address = a;
		bus_pins.data = wr ? d : ~bus_pins.data;
		@(negedge clock);
		bus_pins.write_n = !wr;
		bus_pins.read_n = wr;
		repeat (6) @(negedge clock);
		q = data_oe ? data_out : 28'hx;
		bus_pins.write_n = 1'b1;
		bus_pins.read_n = 1'b1;
		repeat (5) @(negedge clock);
		bus_pins.chip_select_n = 1'b1;
		bus_pins.address = ~a;
		bus_pins.data = ~bus_pins.data;
	endtask

	task automatic access(input logic [3:0] a, input logic [27:0] d,
			input bit wr, output logic [27:0] q);
		logic [27:0] lo;
		logic [27:0] hi;
		if (!half)
			strobe(a, d, wr, q);
		else begin
			strobe(a, {12'h0, d[15:0]}, wr, lo);
			strobe(a, {16'h0, d[27:16]}, wr, hi);
			q = {hi[11:0], lo[15:0]};
		end
		if (wr && a == 4'he)
			half = d[4];
	endtask
endmodule

// ==== test_tdc_config_readout_registers.sv ====
// Self-checking bench of the register bank against a behavioural model.
`timescale 1ns/1ns
module test_tdc_config_readout_registers;
	import tdc_regs_pkg::*;
	localparam int DEPTH = 32;
	logic        clock;
	logic        resetn;
	bus_pins_t   bus_pins;
	logic [27:0] data_out;
	logic        data_oe;
	logic        alu_trigger_pin;
	logic        output_enable_pin;
	meas_mode_t  meas_mode;
	logic        quiet_mode;
	logic        output_enable_pin_spare;
	logic        start_pulse;
	logic [16:0] first_start_gap;
	hit_t        hit_one;
	logic        hit_one_valid;
	logic        hit_one_ready;
	hit_t        hit_two;
	logic        hit_two_valid;
	logic        hit_two_ready;
	config_t     config_out;
	logic        stop_inputs_enabled;
	logic        start_input_enabled;
	logic        full_reset;
	logic        part_reset;
	logic [1:0]  fifo_level_flag;
	logic [1:0]  fifo_empty;
	int          miscompares;
	int          n_compared;
	int          i;
	int          k;
	bit          took;
	logic [27:0] regs [16];
	logic [27:0] q1 [$];
	logic [27:0] q2 [$];

	tdc_config_readout_registers #(.FIFO_DEPTH(DEPTH)) i_dut (
		.clock(clock), .resetn(resetn), .bus_pins(bus_pins),
		.data_out(data_out), .data_oe(data_oe),
		.alu_trigger_pin(alu_trigger_pin),
		.output_enable_pin(output_enable_pin), .meas_mode(meas_mode),
		.quiet_mode(quiet_mode),
		.output_enable_pin_spare(output_enable_pin_spare),
		.start_pulse(start_pulse), .first_start_gap(first_start_gap),
		.hit_one(hit_one), .hit_one_valid(hit_one_valid),
		.hit_one_ready(hit_one_ready), .hit_two(hit_two),
		.hit_two_valid(hit_two_valid), .hit_two_ready(hit_two_ready),
		.config_out(config_out), .stop_inputs_enabled(stop_inputs_enabled),
		.start_input_enabled(start_input_enabled), .full_reset(full_reset),
		.part_reset(part_reset), .fifo_level_flag(fifo_level_flag),
		.fifo_empty(fifo_empty));

	tdc_host_model i_host (
		.clock(clock), .bus_pins(bus_pins), .data_out(data_out),
		.data_oe(data_oe));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check_word(input logic [27:0] got, input logic [27:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic [1:0] got, input logic [1:0] exp);
		check_word({26'h0, got}, {26'h0, exp});
	endtask

	task automatic test_done;
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [27:0] cfg_word(input logic [3:0] a);
		config_t c;
		c = config_out;
		case (a)
		4'h5: return {c.external_start_repeat,
			c.part_reset_on_output_enable_pin,
			c.full_reset_on_output_enable_pin, c.part_reset_on_trigger_pin,
			c.full_reset_on_trigger_pin, c.start_gate_after_start,
			c.stop_gate_until_start, c.service_adjust_bits,
			c.start_offset_primary};
		4'h6: return {c.differential_receiver_power,
			c.differential_input_routing, c.start_offset_secondary,
			c.fifo_fill_threshold};
		4'h7: return {c.measurement_timer, c.pll_service_bit,
			c.pll_loop_open, c.pll_phase_invert, c.resolution_regulation_on,
			c.pll_reference_divider, c.pll_fast_divider};
		default: return {23'h0, c.half_width_bus_mode, 4'h0};
		endcase
	endfunction

	task automatic wr(input logic [3:0] a, input logic [27:0] d);
		logic [27:0] q;
		i_host.access(a, d, 1'b1, q);
		if (a inside {4'h5, 4'h6, 4'h7})
			regs[a] = d;
		if (a == 4'he)
			regs[a] = d & 28'h10;
	endtask

	task automatic rd_check(input logic [3:0] a);
		logic [27:0] q;
		logic [27:0] e;
		i_host.access(a, 28'h0, 1'b0, q);
		e = 28'h0;
		case (a)
		4'h5, 4'h7, 4'he: e = regs[a];
		4'h6: e = regs[a] ^ 28'hff;
		4'h8: if (q1.size() > 0) e = q1.pop_front();
		4'h9: if (q2.size() > 0) e = q2.pop_front();
		4'ha: if (meas_mode == MODE_EIGHT_CHANNEL) e = {11'h0, first_start_gap};
		default: e = 28'h0;
		endcase
		check_word(q, e);
	endtask

	// Offers one hit; the model keeps it only if the queue showed ready.
	task automatic push(input bit two, output bit ok);
		hit_t        h;
		logic [27:0] w;
		h = hit_t'(34'({$urandom, $urandom}));
		meas_mode = meas_mode_t'(2'($urandom));
		case (meas_mode)
		MODE_EIGHT_CHANNEL: w = {h.channel_index, h.start_number,
			h.edge_direction, h.interval[16:0]};
		MODE_TWO_CHANNEL_FINE: w = {5'h0, h.edge_direction, h.interval[21:0]};
		default: w = {5'h0, h.interval};
		endcase
		ok = two ? hit_two_ready : hit_one_ready;
		hit_one = h;
		hit_two = h;
		hit_one_valid = !two;
		hit_two_valid = two;
		if (ok && two)
			q2.push_back(w);
		if (ok && !two)
			q1.push_back(w);
		@(negedge clock);
		hit_one_valid = 1'b0;
		hit_two_valid = 1'b0;
		@(negedge clock);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		test_done;
	end

	initial begin
		resetn = 1'b0;
		alu_trigger_pin = 1'b0;
		output_enable_pin = 1'b1;
		meas_mode = MODE_TWO_CHANNEL;
		quiet_mode = 1'b0;
		output_enable_pin_spare = 1'b1;
		start_pulse = 1'b0;
		first_start_gap = 17'h0;
		hit_one = '0;
		hit_two = '0;
		hit_one_valid = 1'b0;
		hit_two_valid = 1'b0;
		miscompares = 0;
		n_compared = 0;
		foreach (regs[j])
			regs[j] = 28'h0;
		void'($urandom(9));
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		check_flag(fifo_empty, 2'b11);
		rd_check(4'h6);
		for (k = 0; k < 4; k++) begin
			wr(4'h5, 28'($urandom));
			wr(4'h6, 28'($urandom));
			wr(4'h7, 28'($urandom) & 28'hfffbfff);
			wr(4'h3, 28'($urandom));
			check_word(cfg_word(4'h5), regs[5]);
			check_word(cfg_word(4'h6), regs[6]);
			check_word(cfg_word(4'h7), regs[7]);
			rd_check(4'h5);
			rd_check(4'h6);
			rd_check(4'h7);
			rd_check(4'h3);
		end
		wr(4'he, 28'h0);
		rd_check(4'he);
		for (k = 0; k < 8; k++) begin
			i = 23 + k % 4;
			wr(4'h5, 28'h1 << i);
			quiet_mode = k > 3;
			output_enable_pin_spare = k < 4;
			alu_trigger_pin = i < 25;
			output_enable_pin = i < 25;
			repeat (5) @(negedge clock);
			check_flag({full_reset, part_reset},
				k > 3 ? 2'b00 : (i % 2 ? 2'b10 : 2'b01));
			alu_trigger_pin = 1'b0;
			output_enable_pin = 1'b1;
			repeat (5) @(negedge clock);
			check_flag({full_reset, part_reset}, 2'b00);
		end
		quiet_mode = 1'b0;
		output_enable_pin_spare = 1'b1;
		meas_mode = MODE_TWO_CHANNEL_FINE;
		wr(4'h5, 28'h60_0000);
		check_flag({stop_inputs_enabled, start_input_enabled}, 2'b01);
		start_pulse = 1'b1;
		@(negedge clock);
		start_pulse = 1'b0;
		repeat (3) @(negedge clock);
		check_flag({stop_inputs_enabled, start_input_enabled}, 2'b10);
		meas_mode = MODE_EIGHT_CHANNEL;
		repeat (3) @(negedge clock);
		check_flag({stop_inputs_enabled, start_input_enabled}, 2'b11);
		wr(4'h6, 28'h20);
		for (k = 0; k < 3; k++)
			push(1'b1, took);
		k = 0;
		for (i = 0; i < 40; i++) begin
			push(1'b0, took);
			k += took;
		end
		check_word(28'(k), 28'(DEPTH));
		check_flag(fifo_level_flag, 2'b01);
		check_flag(fifo_empty, 2'b00);
		rd_check(4'h8);
		check_flag(fifo_level_flag, 2'b00);
		while (q2.size() > 0)
			rd_check(4'h9);
		rd_check(4'h9);
		while (q1.size() > 0)
			rd_check(4'h8);
		check_flag(fifo_empty, 2'b11);
		first_start_gap = 17'($urandom);
		meas_mode = MODE_EIGHT_CHANNEL;
		rd_check(4'ha);
		meas_mode = MODE_TWO_CHANNEL;
		rd_check(4'ha);
		wr(4'he, 28'h10);
		check_word(cfg_word(4'he), 28'h10);
		wr(4'h7, 28'($urandom) & 28'hfffbfff);
		rd_check(4'h7);
		rd_check(4'he);
		check_word(cfg_word(4'h7), regs[7]);
		test_done;
	end
endmodule
